// file: design/host_dte_end.sv
// Terminal (DTE) end: drives the modem pins from registers that
// software reaches over AXI4-Lite. Assumes one master on the bus.
`timescale 1ns/10ps
`default_nettype none
module host_dte_end
  import modem_serial_pkg::*;
#(
  parameter int BAUD_DIV_DEF = BAUD_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  host_serial_if.host pins,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [1:0] rxd_s, cts_s;
  logic [6:0] st0_s, st1_s;
  logic [3:0] ctrl_reg;
  logic aw_hold, w_hold, rx_avail, tx_go, tx_ready, rx_valid;
  logic [7:0] aw_addr, rx_byte, rx_data;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write, rd_rx;

  function automatic logic known(input logic [7:0] a);
    known = (a == CTRL_OFS) || (a == STATUS_OFS) ||
            (a == TXDATA_OFS) || (a == RXDATA_OFS);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_s <= 2'h3;
      cts_s <= 2'h3;
      st0_s <= 7'h7F;
      st1_s <= 7'h7F;
    end else begin
      rxd_s <= {rxd_s[0], pins.rxd};
      cts_s <= {cts_s[0], pins.cts_n};
      st0_s <= {pins.pdok_n, pins.tx_keyed_n, pins.chan_led_n,
                pins.ri_n, pins.dsr_n, pins.dcd_n, pins.cts_n};
      st1_s <= st0_s;
    end
  end

  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_hold && w_hold && !s_axi_bvalid;
  assign tx_go = do_write && (aw_addr == TXDATA_OFS) && w_strb[0];
  assign rd_rx = s_axi_arvalid && s_axi_arready &&
                 (s_axi_araddr == RXDATA_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl_reg <= CTRL_RESET_VAL;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        if (aw_addr == CTRL_OFS && w_strb[0]) ctrl_reg <= w_data[3:0];
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr == CTRL_OFS) begin
        s_axi_rdata <= {28'h0000000, ctrl_reg};
      end else if (s_axi_araddr == STATUS_OFS) begin
        s_axi_rdata <= {23'h000000, !tx_ready, rx_avail, ~st1_s};
      end else if (s_axi_araddr == RXDATA_OFS) begin
        s_axi_rdata <= {24'h000000, rx_byte};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // A byte landing in the same cycle as the read keeps the flag set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_avail <= 1'b0;
      rx_byte <= 8'h00;
    end else if (rx_valid) begin
      rx_avail <= 1'b1;
      rx_byte <= rx_data;
    end else if (rd_rx) begin
      rx_avail <= 1'b0;
    end
  end

  serial_byte_engine u_engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .div(DIV_W'(BAUD_DIV_DEF)),
    .tx_data(w_data[7:0]),
    .tx_valid(tx_go),
    .tx_gate(!cts_s[1]),
    .tx_ready(tx_ready),
    .txd(pins.txd),
    .rxd(rxd_s[1]),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_frame_err()
  );

  // An unread byte holds RTS off so the modem does not overrun it.
  assign pins.rts_n = !(ctrl_reg[CTRL_RTS_BIT] && !rx_avail);
  assign pins.dtr_n = !ctrl_reg[CTRL_DTR_BIT];
  assign pins.graceful_shutdown_n_n = !ctrl_reg[CTRL_GRACEFUL_SHUTDOWN_N_BIT];
  assign pins.hw_reset_n = !ctrl_reg[CTRL_RESET_BIT];
  assign pins.spare_in = 4'hF;
endmodule // host_dte_end
`default_nettype wire

// file: design/host_serial_if.sv
// Pin bundle between the terminal (host) and the modem.
// All wires are plain logic levels; the bench joins the two ends.
`timescale 1ns/10ps
`default_nettype none
interface host_serial_if;
  logic txd;
  logic rxd;
  logic dtr_n;
  logic rts_n;
  logic cts_n;
  logic dcd_n;
  logic dsr_n;
  logic ri_n;
  logic graceful_shutdown_n_n;
  logic hw_reset_n;
  logic chan_led_n;
  logic tx_keyed_n;
  logic pdok_n;
  logic chan_led_wl_n;
  logic tx_keyed_wl_n;
  logic [3:0] spare_in;
  modport device (
    input txd, dtr_n, rts_n, graceful_shutdown_n_n, hw_reset_n, spare_in,
    output rxd, cts_n, dcd_n, dsr_n, ri_n, chan_led_n, tx_keyed_n,
    output pdok_n, chan_led_wl_n, tx_keyed_wl_n
  );
  modport host (
    output txd, dtr_n, rts_n, graceful_shutdown_n_n, hw_reset_n, spare_in,
    input rxd, cts_n, dcd_n, dsr_n, ri_n, chan_led_n, tx_keyed_n,
    input pdok_n, chan_led_wl_n, tx_keyed_wl_n
  );
endinterface // host_serial_if
`default_nettype wire

// file: design/modem_dce_end.sv
// Modem (DCE) end of the host serial link: data port, handshake lines,
// shutdown and status pins. Assumes the host keeps its own duties.
// Behaviour
// - RTS and CTS gate data both ways.
// - Host holds DTR active while running.
// - DCD shows session or carrier setting.
// - DSR stays low while powered.
// - RI toggles while a call rings.
// - RI idle in packet mode normally.
// - Optional RI wake toggling when DTR off.
// - Frames are 8 data, no parity, 1 stop.
// - Default rate is 19200 bps.
// - Autobaud from first character, or fixed rate.
// - Shutdown deregisters, then power-down-ok goes low.
// - Dead after shutdown until reset.
// - Modem resets while reset pin low.
// - Status outputs are active low.
// - LED low without channel, high in sleep; code forces it high in sleep in packet mode only.
// - Channel acquired: 1 Hz, 10% low.
// - Registered: 2 Hz, 10% low.
// - TX keyed pin low while keyed.
// - Spare inputs have no effect.
// - Wireline copies of LED and keyed pins.
// - Host terminates unused lines inactive.
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module modem_dce_end
  import modem_serial_pkg::*;
#(
  parameter int BAUD_DIV_DEF = BAUD_DIV,
  parameter int LED_SLOW = LED_SLOW_CYC,
  parameter int LED_FAST = LED_FAST_CYC,
  parameter int RING_TOGGLE = RING_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  host_serial_if.device pins,
  input wire link_mode_t mode,
  input wire logic channel_acquired,
  input wire logic registered,
  input wire logic logic_sleep,
  input wire logic transmitter_keyed,
  input wire logic ringing,
  input wire logic session_online,
  input wire logic carrier_behaviour_cmd,
  input wire dtr_action_t terminal_ready_behaviour_cmd,
  input wire logic ri_wake_en,
  input wire logic data_for_host,
  input wire logic deregister_done,
  input wire logic autobaud_en,
  input wire logic baud_fix_en,
  input wire logic [DIV_W-1:0] baud_fix_div,
  input wire logic [DATA_BITS-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [DATA_BITS-1:0] rx_data,
  output logic rx_valid,
  output logic rx_frame_err,
  input wire logic rx_ready,
  output logic host_active,
  output logic to_command,
  output logic dtr_reset_req,
  output logic deregister_req,
  output logic shutdown_done
);
  localparam int LED_SLOW_ON = LED_SLOW / 100 * LED_DUTY_PCT;
  localparam int LED_FAST_ON = LED_FAST / 100 * LED_DUTY_PCT;
  logic [1:0] txd_s, dtr_s, rts_s, graceful_shutdown_n_s, hwr_s;
  logic rst_n;
  power_state_t pwr_reg;
  logic dtr_prev;
  logic [DIV_W-1:0] div_reg, ab_cnt;
  logic ab_armed, ab_meas;
  logic [CNT_W-1:0] led_cnt, ring_cnt;
  logic led_reg, led_next, ri_reg, ring_active, keyed_reg;
  logic dcd_reg, cts_reg, run;
  logic [DATA_BITS-1:0] eng_rx_data;
  logic eng_rx_valid, eng_rx_err, txd_eng;

  // Pins from the host, bar the spare inputs, cross into aclk through two flops each.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_s <= 2'h3;
      dtr_s <= 2'h3;
      rts_s <= 2'h3;
      graceful_shutdown_n_s <= 2'h3;
      hwr_s <= 2'h0;
    end else begin
      txd_s <= {txd_s[0], pins.txd};
      dtr_s <= {dtr_s[0], pins.dtr_n};
      rts_s <= {rts_s[0], pins.rts_n};
      graceful_shutdown_n_s <= {graceful_shutdown_n_s[0], pins.graceful_shutdown_n_n};
      hwr_s <= {hwr_s[0], pins.hw_reset_n};
    end
  end

  assign rst_n = aresetn && hwr_s[1];
  assign run = (pwr_reg == PWR_RUN);

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      pwr_reg <= PWR_RUN;
    end else begin
      case (pwr_reg)
        PWR_RUN: if (!graceful_shutdown_n_s[1]) pwr_reg <= PWR_DEREG;
        PWR_DEREG: if (deregister_done) pwr_reg <= PWR_OFF;
        PWR_OFF: pwr_reg <= PWR_OFF;
        default: pwr_reg <= PWR_RUN;
      endcase
    end
  end

  assign deregister_req = (pwr_reg == PWR_DEREG);
  assign shutdown_done = (pwr_reg == PWR_OFF);

  // DTR going inactive triggers the configured action once.
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      dtr_prev <= 1'b1;
      host_active <= 1'b0;
      to_command <= 1'b0;
      dtr_reset_req <= 1'b0;
    end else begin
      dtr_prev <= dtr_s[1];
      host_active <= !dtr_s[1];
      to_command <= run && dtr_s[1] && !dtr_prev &&
        (terminal_ready_behaviour_cmd == DTR_TO_COMMAND);
      dtr_reset_req <= run && dtr_s[1] && !dtr_prev &&
        (terminal_ready_behaviour_cmd == DTR_RESET);
    end
  end

  // The first low stretch after arming is the start bit of 'A', whose
  // first data bit is high, so it measures exactly one bit time.
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      div_reg <= DIV_W'(BAUD_DIV_DEF);
      ab_armed <= 1'b1;
      ab_meas <= 1'b0;
      ab_cnt <= '0;
    end else if (baud_fix_en) begin
      div_reg <= baud_fix_div;
    end else if (autobaud_en && ab_armed) begin
      if (!ab_meas && !txd_s[1]) begin
        ab_meas <= 1'b1;
        ab_cnt <= DIV_W'(1);
      end else if (ab_meas && !txd_s[1]) begin
        if (ab_cnt != DIV_W'(BAUD_DIV_MAX)) ab_cnt <= ab_cnt + 1'b1;
      end else if (ab_meas) begin
        ab_meas <= 1'b0;
        if (ab_cnt >= DIV_W'(BAUD_DIV_MIN)) begin
          div_reg <= ab_cnt;
          ab_armed <= 1'b0;
        end
      end
    end
  end

  serial_byte_engine u_engine (
    .aclk(aclk),
    .aresetn(rst_n),
    .div(div_reg),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_gate(run && !rts_s[1]),
    .tx_ready(tx_ready),
    .txd(txd_eng),
    .rxd(txd_s[1]),
    .rx_data(eng_rx_data),
    .rx_valid(eng_rx_valid),
    .rx_frame_err(eng_rx_err)
  );

  // Characters arriving after shutdown are dropped.
  assign rx_data = eng_rx_data;
  assign rx_valid = eng_rx_valid && run;
  assign rx_frame_err = eng_rx_err && run;

  assign ring_active = (mode != MODE_PACKET) ? ringing
    : (ri_wake_en && dtr_s[1] && data_for_host);

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      ring_cnt <= '0;
      ri_reg <= 1'b1;
    end else if (!ring_active || !run) begin
      ring_cnt <= '0;
      ri_reg <= 1'b1;
    end else if (ring_cnt == CNT_W'(RING_TOGGLE - 1)) begin
      ring_cnt <= '0;
      ri_reg <= !ri_reg;
    end else begin
      ring_cnt <= ring_cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      led_cnt <= '0;
    end else if (registered ? (led_cnt >= CNT_W'(LED_FAST - 1))
                            : (led_cnt >= CNT_W'(LED_SLOW - 1))) begin
      led_cnt <= '0;
    end else begin
      led_cnt <= led_cnt + 1'b1;
    end
  end

  always_comb begin
    if (!run || (mode == MODE_PACKET && logic_sleep)) begin
      led_next = 1'b1;
    end else if (registered) begin
      led_next = !(led_cnt < CNT_W'(LED_FAST_ON));
    end else if (channel_acquired) begin
      led_next = !(led_cnt < CNT_W'(LED_SLOW_ON));
    end else begin
      led_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      led_reg <= 1'b0;
      keyed_reg <= 1'b1;
      dcd_reg <= 1'b1;
      cts_reg <= 1'b1;
    end else begin
      led_reg <= led_next;
      keyed_reg <= !(transmitter_keyed && run);
      if (mode == MODE_PACKET || carrier_behaviour_cmd) begin
        dcd_reg <= !(session_online && run);
      end else begin
        dcd_reg <= !run;
      end
      cts_reg <= !(rx_ready && run);
    end
  end

  // Spare inputs are deliberately never read, so floating is harmless.
  assign pins.rxd = txd_eng;
  assign pins.cts_n = cts_reg;
  assign pins.dcd_n = dcd_reg;
  assign pins.dsr_n = 1'b0;
  assign pins.ri_n = ri_reg;
  assign pins.chan_led_n = led_reg;
  assign pins.tx_keyed_n = keyed_reg;
  assign pins.pdok_n = !shutdown_done;
  assign pins.chan_led_wl_n = led_reg;
  assign pins.tx_keyed_wl_n = keyed_reg;
endmodule // modem_dce_end
`default_nettype wire

// file: design/modem_serial_pkg.sv
// Shared constants and types for the modem host serial link.
// Assumes a 100 MHz system clock on both ends.
package modem_serial_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_BPS = 19200;
  localparam int BAUD_MAX_BPS = 115200;
  localparam int BAUD_MIN_BPS = 110;
  localparam int DIV_W = 20;
  localparam int BAUD_DIV = CLK_HZ / BAUD_BPS;
  localparam int BAUD_DIV_MIN = CLK_HZ / BAUD_MAX_BPS;
  localparam int BAUD_DIV_MAX = CLK_HZ / BAUD_MIN_BPS;
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int LED_SLOW_MS = 1000;
  localparam int LED_FAST_MS = 500;
  localparam int LED_DUTY_PCT = 10;
  localparam int RING_TOGGLE_MS = 500;
  localparam int LED_SLOW_CYC = LED_SLOW_MS * MS_CYC;
  localparam int LED_FAST_CYC = LED_FAST_MS * MS_CYC;
  localparam int RING_CYC = RING_TOGGLE_MS * MS_CYC;
  localparam int CNT_W = 27;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] TXDATA_OFS = 8'h08;
  localparam logic [7:0] RXDATA_OFS = 8'h0C;
  localparam int CTRL_RTS_BIT = 0;
  localparam int CTRL_DTR_BIT = 1;
  localparam int CTRL_GRACEFUL_SHUTDOWN_N_BIT = 2;
  localparam int CTRL_RESET_BIT = 3;
  localparam logic [3:0] CTRL_RESET_VAL = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    MODE_PACKET = 2'h0, MODE_CSC = 2'h1, MODE_WIRELINE = 2'h2
  } link_mode_t;
  typedef enum logic [1:0] {
    DTR_IGNORE = 2'h0, DTR_TO_COMMAND = 2'h1, DTR_RESET = 2'h2
  } dtr_action_t;
  typedef enum logic [2:0] {
    PWR_RUN = 3'b001, PWR_DEREG = 3'b010, PWR_OFF = 3'b100
  } power_state_t;
endpackage

// file: design/serial_byte_engine.sv
// Byte transmitter and receiver for 8N1 asynchronous frames.
// Assumes rxd is already synchronised to aclk and div is held steady.
`timescale 1ns/10ps
`default_nettype none
module serial_byte_engine
  import modem_serial_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [DIV_W-1:0] div,
  input wire logic [DATA_BITS-1:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_gate,
  output logic tx_ready,
  output logic txd,
  input wire logic rxd,
  output logic [DATA_BITS-1:0] rx_data,
  output logic rx_valid,
  output logic rx_frame_err
);
  localparam logic [3:0] FRAME_REST = 4'(DATA_BITS + STOP_BITS);
  logic tx_busy;
  logic [DIV_W-1:0] tx_tmr;
  logic [3:0] tx_left;
  logic [DATA_BITS:0] tx_shift;
  logic rx_busy;
  logic [DIV_W-1:0] rx_tmr;
  logic [3:0] rx_idx;
  logic [DATA_BITS-1:0] rx_shift;
  logic tx_tick;
  logic rx_tick;

  assign tx_tick = (tx_tmr == div - 1'b1);
  assign rx_tick = (rx_tmr == div - 1'b1);
  assign tx_ready = !tx_busy && tx_gate;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_busy <= 1'b0;
      txd <= 1'b1;
      tx_tmr <= '0;
      tx_left <= 4'h0;
      tx_shift <= '1;
    end else if (!tx_busy) begin
      if (tx_valid && tx_gate) begin
        tx_busy <= 1'b1;
        txd <= 1'b0;
        tx_shift <= {1'b1, tx_data};
        tx_left <= FRAME_REST;
        tx_tmr <= '0;
      end
    end else if (tx_tick) begin
      tx_tmr <= '0;
      if (tx_left == 4'h0) begin
        tx_busy <= 1'b0;
      end else begin
        txd <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[DATA_BITS:1]};
        tx_left <= tx_left - 4'h1;
      end
    end else begin
      tx_tmr <= tx_tmr + 1'b1;
    end
  end

  // Sampling starts half a bit in, so each bit is read at its centre.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_busy <= 1'b0;
      rx_tmr <= '0;
      rx_idx <= 4'h0;
      rx_shift <= '0;
      rx_data <= '0;
      rx_valid <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      rx_frame_err <= 1'b0;
      if (!rx_busy) begin
        if (!rxd) begin
          rx_busy <= 1'b1;
          rx_tmr <= div >> 1;
          rx_idx <= 4'h0;
        end
      end else if (rx_tick) begin
        rx_tmr <= '0;
        rx_idx <= rx_idx + 4'h1;
        if (rx_idx == 4'h0) begin
          rx_busy <= !rxd;
        end else if (rx_idx == FRAME_REST) begin
          rx_busy <= 1'b0;
          rx_data <= rx_shift;
          rx_valid <= rxd;
          rx_frame_err <= !rxd;
        end else begin
          rx_shift <= {rxd, rx_shift[DATA_BITS-1:1]};
        end
      end else begin
        rx_tmr <= rx_tmr + 1'b1;
      end
    end
  end
endmodule // serial_byte_engine
`default_nettype wire

// file: dv/modem_link_props.sv
// Checks on the pin bundle between the host and modem ends.
// Assumes one clock; DIV is the bit time in clocks on both ends.
`timescale 1ns/10ps
`default_nettype none
module modem_link_props #(
  parameter int DIV = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic txd,
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic dcd_n,
  input wire logic dsr_n,
  input wire logic hw_reset_n,
  input wire logic chan_led_n,
  input wire logic tx_keyed_n,
  input wire logic pdok_n,
  input wire logic chan_led_wl_n,
  input wire logic tx_keyed_wl_n
);
  localparam int MAXLO = 9 * DIV;
  logic [8:0] rx_lo;
  logic [8:0] tx_lo;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A low run is whole bits: a start bit plus at most eight zeros.
  always_ff @(posedge aclk) begin
    rx_lo <= (!aresetn || rxd) ? 9'h000 : rx_lo + 9'h001;
  end
  always_ff @(posedge aclk) begin
    tx_lo <= (!aresetn || txd) ? 9'h000 : tx_lo + 9'h001;
  end
  a_rx_frame_shape: assert property (
    $rose(rxd) |-> rx_lo % DIV == 0 && rx_lo <= MAXLO)
    else $error("rxd low run is not whole bits");
  a_tx_frame_shape: assert property (
    $rose(txd) |-> tx_lo % DIV == 0 && tx_lo <= MAXLO)
    else $error("txd low run is not whole bits");
  a_dsr_held_low: assert property (dsr_n == 1'b0)
    else $error("dsr_n not low");
  a_led_copy_exact: assert property (chan_led_wl_n == chan_led_n)
    else $error("led copy differs");
  a_keyed_copy_exact: assert property (
    tx_keyed_wl_n == tx_keyed_n)
    else $error("keyed copy differs");
  a_hw_reset_idle: assert property (
    !hw_reset_n [*4] |-> pdok_n && cts_n && rxd && !chan_led_n && tx_keyed_n)
    else $error("outputs not idle in reset");
  a_pdok_latched: assert property (
    hw_reset_n [*4] ##0 !pdok_n |=> !pdok_n)
    else $error("pdok_n left low without reset");
  a_shutdown_quiet: assert property (
    !pdok_n [*3] |-> chan_led_n && cts_n && dcd_n)
    else $error("lines active after shutdown");
  c_pdok: cover property ($fell(pdok_n));
  c_rx_frame: cover property ($rose(rxd) ##1 rxd);
  c_led_pulse: cover property ($fell(chan_led_n) ##[1:40] $rose(chan_led_n));
endmodule // modem_link_props
`default_nettype wire

// file: dv/tb_top.sv
// Bench: host and modem ends joined by one pin bundle.
// Drives AXI4-Lite on the host and the user side of the modem.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import modem_serial_pkg::*;
  localparam int DIV = 16;
  localparam logic [5:0] CFG [7] = '{6'h10, 6'h18, 6'h04, 6'h00, 6'h22,
    6'h02, 6'h01};
  localparam int LOWS [7] = '{40, 40, 0, 400, 400, 400, 400};
  localparam int TOGS [7] = '{0, 0, 0, 0, 8, 0, 8};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  link_mode_t mode = MODE_PACKET;
  logic chan = 1'b0, regd = 1'b0, slp = 1'b0, keyed = 1'b0, ring = 1'b0;
  logic sess = 1'b0, wake = 1'b0, ddone = 1'b0, txv = 1'b0, rxrdy = 1'b1;
  logic [7:0] txb = 8'h00, b, rxb, awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic txr, rxv, hact, dreq, sdone, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [5:0] c;
  logic ccmd = 1'b0, tocmd, dtrst, ferr;
  dtr_action_t dact = DTR_TO_COMMAND;
  logic [33:0] exp_rd [$];
  logic [33:0] exp_rx [$];
  int fail_count = 0;
  int checks_done = 0;
  int lo, tg, ncmd = 0, nrst = 0;
  host_serial_if bus();
  always #5 aclk = ~aclk;
  modem_dce_end #(.BAUD_DIV_DEF(DIV), .LED_SLOW(200), .LED_FAST(100),
    .RING_TOGGLE(50)) i_modem_dce_end (
    .aclk(aclk), .aresetn(aresetn), .pins(bus.device), .mode(mode),
    .channel_acquired(chan), .registered(regd), .logic_sleep(slp),
    .transmitter_keyed(keyed), .ringing(ring), .session_online(sess),
    .carrier_behaviour_cmd(ccmd), .ri_wake_en(wake),
    .terminal_ready_behaviour_cmd(dact), .data_for_host(wake),
    .deregister_done(ddone), .autobaud_en(1'b0), .baud_fix_en(1'b0),
    .baud_fix_div(20'h00010), .tx_data(txb), .tx_valid(txv),
    .tx_ready(txr), .rx_data(rxb), .rx_valid(rxv), .rx_frame_err(ferr),
    .rx_ready(rxrdy), .host_active(hact), .to_command(tocmd),
    .dtr_reset_req(dtrst), .deregister_req(dreq), .shutdown_done(sdone));
  host_dte_end #(.BAUD_DIV_DEF(DIV)) i_host_dte_end (
    .aclk(aclk), .aresetn(aresetn), .pins(bus.host),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  modem_link_props #(.DIV(DIV)) i_modem_link_props (
    .aclk(aclk), .aresetn(aresetn), .txd(bus.txd), .rxd(bus.rxd),
    .cts_n(bus.cts_n), .dcd_n(bus.dcd_n), .dsr_n(bus.dsr_n),
    .hw_reset_n(bus.hw_reset_n), .chan_led_n(bus.chan_led_n),
    .tx_keyed_n(bus.tx_keyed_n), .pdok_n(bus.pdok_n),
    .chan_led_wl_n(bus.chan_led_wl_n), .tx_keyed_wl_n(bus.tx_keyed_wl_n));
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_rd.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic watch(input int n, output int l, output int t);
    logic p;
    l = 0;
    t = 0;
    p = bus.ri_n;
    repeat (n) begin
      @(posedge aclk);
      l += int'(bus.chan_led_n === 1'b0);
      t += int'(bus.ri_n !== p);
      p = bus.ri_n;
    end
  endtask
  // Results are queued by the driver, so a dropped byte shows as a miss.
  always @(posedge aclk) begin
    if (rvalid && rready) chk({rresp, rdata}, exp_rd.size() > 0 ?
      exp_rd.pop_front() : '1);
    if (rxv === 1'b1) chk({26'h0, rxb}, exp_rx.size() > 0 ?
      exp_rx.pop_front() : '1);
    if (ferr === 1'b1) chk(34'h1, 34'h0);
    ncmd += int'(tocmd === 1'b1);
    nrst += int'(dtrst === 1'b1);
  end
  initial begin
    void'($urandom(70));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    wr(CTRL_OFS, 32'h3, 4'hF);
    repeat (10) @(posedge aclk);
    chk({33'h0, hact}, 34'h1);
    for (int i = 0; i < 4; i++) begin
      keyed <= 1'($urandom);
      sess <= 1'($urandom);
      ccmd <= 1'($urandom);
      repeat (8) @(posedge aclk);
      rd(STATUS_OFS, {26'h0, 2'b00, keyed, 3'b101, sess, 1'b1});
    end
    for (int i = 0; i < 4; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      exp_rx.push_back({26'h0, b});
      wr(TXDATA_OFS, {24'h0, b}, 4'hF);
      repeat (200) @(posedge aclk);
    end
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      txb <= b;
      txv <= 1'b1;
      do @(posedge aclk); while (txr !== 1'b1);
      txv <= 1'b0;
      repeat (200) @(posedge aclk);
      rd(RXDATA_OFS, {26'h0, b});
    end
    wr(CTRL_OFS, 32'h0, 4'hE);
    rxrdy <= 1'b0;
    repeat (10) @(posedge aclk);
    chk({33'h0, hact}, 34'h1);
    wr(TXDATA_OFS, 32'hA5, 4'hF);
    repeat (200) @(posedge aclk);
    rd(STATUS_OFS, {26'h1, 2'b00, keyed, 3'b101, sess, 1'b0});
    wr(CTRL_OFS, 32'h2, 4'hF);
    // The modem sees RTS drop only after its two sync flops.
    repeat (4) @(posedge aclk);
    txv <= 1'b1;
    repeat (10) @(posedge aclk);
    chk({33'h0, txr}, 34'h0);
    txv <= 1'b0;
    rxrdy <= 1'b1;
    dact <= DTR_RESET;
    for (int i = 0; i < 7; i++) begin
      c = CFG[i];
      mode <= c[5] ? MODE_CSC : MODE_PACKET;
      {chan, regd, slp, ring, wake} <= c[4:0];
      wr(CTRL_OFS, c[0] ? 32'h1 : 32'h3, 4'hF);
      repeat (20) @(posedge aclk);
      watch(400, lo, tg);
      chk({2'h0, 16'(lo), 16'(tg)}, {2'h0, 16'(LOWS[i]), 16'(TOGS[i])});
    end
    {mode, chan, regd, slp, ring, wake, keyed} <= {MODE_PACKET, 6'h00};
    wr(CTRL_OFS, 32'h7, 4'hF);
    repeat (10) @(posedge aclk);
    chk({33'h0, dreq}, 34'h1);
    ddone <= 1'b1;
    repeat (10) @(posedge aclk);
    ddone <= 1'b0;
    rd(STATUS_OFS, {26'h1, 2'b01, keyed, 3'b001, 2'b00});
    repeat (20) @(posedge aclk);
    chk({32'h0, sdone, txr}, 34'h2);
    wr(CTRL_OFS, 32'hB, 4'hF);
    repeat (10) @(posedge aclk);
    wr(CTRL_OFS, 32'h3, 4'hF);
    repeat (10) @(posedge aclk);
    chk({32'h0, sdone, dreq}, 34'h0);
    exp_rx.push_back(34'h5A);
    wr(TXDATA_OFS, 32'h5A, 4'hF);
    repeat (200) @(posedge aclk);
    rd(8'h10, {RESP_SLVERR, 32'h0});
    dact <= DTR_TO_COMMAND;
    wr(CTRL_OFS, 32'h1, 4'hF);
    repeat (10) @(posedge aclk);
    chk({2'h0, 16'(ncmd), 16'(nrst)}, {2'h0, 16'h1, 16'h1});
    chk(34'(exp_rd.size() + exp_rx.size()), 34'h0);
    final_report();
  end
  initial begin
    repeat (30000) @(posedge aclk);
    fail_count++;
    final_report();
  end
endmodule // tb_top
`default_nettype wire
